//--- pcr_control_reg.v
// Basic control register of the transceiver with strap gating and its MDIO access.
`timescale 1ns/1ps
`include "pcr_map.vh"
module pcr_control_reg (
    // Clock and reset
    input  wire        CLK_SYS_IN,
    input  wire        NRST_IN,
    // Management pins
    input  wire        MDC_IN,
    input  wire        MDIO_IN,
    output wire        MDIO_OUT,
    output wire        MDIO_OE_OUT,
    input  wire [4:0]  PHY_ADDR_IN,
    // Straps and control pins
    input  wire [2:0]  TECHNOLOGY_SELECT_PINS_IN,
    input  wire        AUTONEG_ABILITY_PIN_IN,
    input  wire        FLOAT_DEFAULT_STRAP_IN,
    input  wire        POWER_DOWN_PIN_IN,
    input  wire        ISOLATE_PIN_IN,
    // Mode outputs
    output reg         SPEED_100_OUT,
    output reg         FULL_DUPLEX_OUT,
    output reg         LOOPBACK_ENABLE_OUT,
    output reg         MEDIUM_TX_ENABLE_OUT,
    output reg         MEDIUM_RX_ENABLE_OUT,
    output reg         POWER_DOWN_OUT,
    output reg         MII_OUTPUT_ENABLE_OUT,
    output reg         AUTONEG_ACTIVE_OUT,
    output reg         AUTONEG_RESTART_OUT,
    output reg         SOFT_RESET_OUT,
    output reg  [15:0] BASIC_CONTROL_REG_OUT
);
    reg        loopback_enable_r;
    reg        speed_select_bit_r;
    reg        autoneg_enable_bit_r;
    reg        power_down_request_r;
    reg        isolate_r;
    reg        duplex_r;
    reg        soft_rst_r;
    reg        restart_r;
    reg        strap_load_r;
    wire       wr_stb;
    wire [4:0] reg_addr;
    wire [15:0] wr_data;
    wire [15:0] rd_data;

    function is_10_only;
        input [2:0] t;
        begin
            is_10_only = (t == `PCR_TECH_10_ONLY_A) || (t == `PCR_TECH_10_ONLY_B) ||
                         (t == `PCR_TECH_10_ONLY_C);
        end
    endfunction

    function is_100_only;
        input [2:0] t;
        begin
            is_100_only = (t == `PCR_TECH_100_ONLY_A) || (t == `PCR_TECH_100_ONLY_B) ||
                          (t == `PCR_TECH_100_ONLY_C);
        end
    endfunction

    pcr_mdio_slave u_mdio (
        .clk_in       (CLK_SYS_IN),
        .nrst_in      (NRST_IN),
        .soft_rst_in  (soft_rst_r),
        .mdc_in       (MDC_IN),
        .mdio_in      (MDIO_IN),
        .phy_addr_in  (PHY_ADDR_IN),
        .rd_data_in   (rd_data),
        .mdio_out     (MDIO_OUT),
        .mdio_oe_out  (MDIO_OE_OUT),
        .wr_stb_out   (wr_stb),
        .reg_addr_out (reg_addr),
        .wr_data_out  (wr_data)
    );

    wire ctrl_wr  = wr_stb && (reg_addr == `PCR_ADDR_CTRL);
    wire speed_wr = ctrl_wr && !autoneg_enable_bit_r && (TECHNOLOGY_SELECT_PINS_IN == `PCR_TECH_ANY);

    // Self-clearing bits read as zero; pulses last only one cycle.
    assign rd_data = {1'b0, loopback_enable_r, speed_select_bit_r, autoneg_enable_bit_r,
                      power_down_request_r, isolate_r, 1'b0, duplex_r, 8'h00};

    // Straps are captured by a clocked load cycle after any reset, never by the async reset itself.
    always @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            loopback_enable_r    <= `PCR_RST_LOOPBACK;
            speed_select_bit_r   <= `PCR_RST_SPEED;
            autoneg_enable_bit_r <= 1'b0;
            power_down_request_r <= `PCR_RST_POWER_DOWN_REQUEST;
            isolate_r            <= 1'b0;
            duplex_r             <= `PCR_RST_DUPLEX;
            soft_rst_r           <= 1'b0;
            restart_r            <= 1'b0;
            strap_load_r         <= 1'b1;
        end else if (soft_rst_r) begin
            loopback_enable_r    <= `PCR_RST_LOOPBACK;
            speed_select_bit_r   <= `PCR_RST_SPEED;
            autoneg_enable_bit_r <= 1'b0;
            power_down_request_r <= `PCR_RST_POWER_DOWN_REQUEST;
            isolate_r            <= 1'b0;
            duplex_r             <= `PCR_RST_DUPLEX;
            soft_rst_r           <= 1'b0;
            restart_r            <= 1'b0;
            strap_load_r         <= 1'b1;
        end else begin
            strap_load_r <= 1'b0;
            restart_r    <= 1'b0;
            if (strap_load_r) begin
                autoneg_enable_bit_r <= AUTONEG_ABILITY_PIN_IN;
                isolate_r            <= FLOAT_DEFAULT_STRAP_IN;
                restart_r            <= AUTONEG_ABILITY_PIN_IN;
            end else if (ctrl_wr) begin
                soft_rst_r           <= wr_data[`PCR_BIT_RESET];
                loopback_enable_r    <= wr_data[`PCR_BIT_LOOPBACK];
                power_down_request_r <= wr_data[`PCR_BIT_POWER_DOWN_REQUEST];
                isolate_r            <= wr_data[`PCR_BIT_ISOLATE];
                // A rising ability pin never sets the bit itself; only a write does.
                autoneg_enable_bit_r <= wr_data[`PCR_BIT_ANEG_EN] & AUTONEG_ABILITY_PIN_IN;
                restart_r            <= wr_data[`PCR_BIT_RESTART];
                if (speed_wr) begin
                    speed_select_bit_r <= wr_data[`PCR_BIT_SPEED];
                    duplex_r           <= wr_data[`PCR_BIT_DUPLEX];
                end
            end else if (!AUTONEG_ABILITY_PIN_IN) begin
                autoneg_enable_bit_r <= 1'b0;
            end
            if (!autoneg_enable_bit_r && is_10_only(TECHNOLOGY_SELECT_PINS_IN)) begin
                speed_select_bit_r <= 1'b0;
            end else if (!autoneg_enable_bit_r && is_100_only(TECHNOLOGY_SELECT_PINS_IN)) begin
                speed_select_bit_r <= 1'b1;
            end
        end
    end

    always @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            SPEED_100_OUT         <= 1'b1;
            FULL_DUPLEX_OUT       <= 1'b0;
            LOOPBACK_ENABLE_OUT   <= 1'b0;
            MEDIUM_TX_ENABLE_OUT  <= 1'b0;
            MEDIUM_RX_ENABLE_OUT  <= 1'b0;
            POWER_DOWN_OUT        <= 1'b0;
            MII_OUTPUT_ENABLE_OUT <= 1'b0;
            AUTONEG_ACTIVE_OUT    <= 1'b0;
            AUTONEG_RESTART_OUT   <= 1'b0;
            SOFT_RESET_OUT        <= 1'b0;
            BASIC_CONTROL_REG_OUT <= 16'h0000;
        end else begin
            // SPEED_100_OUT follows this bit even while autonegotiating; no negotiated speed is resolved here.
            SPEED_100_OUT         <= speed_select_bit_r;
            FULL_DUPLEX_OUT       <= duplex_r;
            LOOPBACK_ENABLE_OUT   <= loopback_enable_r;
            MEDIUM_TX_ENABLE_OUT  <= !loopback_enable_r;
            MEDIUM_RX_ENABLE_OUT  <= !loopback_enable_r;
            POWER_DOWN_OUT        <= power_down_request_r | POWER_DOWN_PIN_IN;
            MII_OUTPUT_ENABLE_OUT <= !(isolate_r | ISOLATE_PIN_IN);
            AUTONEG_ACTIVE_OUT    <= autoneg_enable_bit_r;
            AUTONEG_RESTART_OUT   <= restart_r && autoneg_enable_bit_r;
            SOFT_RESET_OUT        <= soft_rst_r;
            BASIC_CONTROL_REG_OUT <= rd_data;
        end
    end
endmodule

//--- pcr_control_reg_asserts.sv
// Port-level checks for the basic control register block.
`timescale 1ns/1ps
module pcr_control_reg_asserts (
    // Clock and reset
    input wire        CLK_SYS_IN,
    input wire        NRST_IN,
    // Straps and pins
    input wire [2:0]  TECHNOLOGY_SELECT_PINS_IN,
    input wire        AUTONEG_ABILITY_PIN_IN,
    input wire        POWER_DOWN_PIN_IN,
    input wire        ISOLATE_PIN_IN,
    // Mode outputs
    input wire        SPEED_100_OUT,
    input wire        LOOPBACK_ENABLE_OUT,
    input wire        MEDIUM_TX_ENABLE_OUT,
    input wire        MEDIUM_RX_ENABLE_OUT,
    input wire        POWER_DOWN_OUT,
    input wire        MII_OUTPUT_ENABLE_OUT,
    input wire        AUTONEG_ACTIVE_OUT,
    input wire        AUTONEG_RESTART_OUT,
    input wire        SOFT_RESET_OUT,
    input wire [15:0] BASIC_CONTROL_REG_OUT
);
    wire t10;
    wire t100;
    assign t10 = TECHNOLOGY_SELECT_PINS_IN >= 3'h1 && TECHNOLOGY_SELECT_PINS_IN <= 3'h3;
    assign t100 = TECHNOLOGY_SELECT_PINS_IN >= 3'h4 && TECHNOLOGY_SELECT_PINS_IN <= 3'h6;
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!NRST_IN);
    // Two cycles of a steady cause are needed because the outputs are registered.
    sequence s_ten;
        (t10 && !AUTONEG_ACTIVE_OUT) [*2];
    endsequence
    sequence s_hund;
        (t100 && !AUTONEG_ACTIVE_OUT) [*2];
    endsequence
    sequence s_abil_rise;
        !AUTONEG_ABILITY_PIN_IN ##1 (AUTONEG_ABILITY_PIN_IN && !AUTONEG_ACTIVE_OUT);
    endsequence
    a_ten_forced: assert property (s_ten |=> !SPEED_100_OUT) else $error("speed not held at 10");
    a_hund_forced: assert property (s_hund |=> SPEED_100_OUT) else $error("speed not held at 100");
    a_abil_low: assert property (!AUTONEG_ABILITY_PIN_IN [*2] |=> !AUTONEG_ACTIVE_OUT) else $error("autoneg on");
    a_abil_rise: assert property (s_abil_rise |=> !AUTONEG_ACTIVE_OUT) else $error("autoneg set by pin");
    a_soft_defaults: assert property (SOFT_RESET_OUT |=> !SOFT_RESET_OUT ##[0:2] !LOOPBACK_ENABLE_OUT)
        else $error("soft reset not applied");
    a_restart_pulse: assert property (AUTONEG_RESTART_OUT |=> !AUTONEG_RESTART_OUT) else $error("restart held");
    a_pwr_pin: assert property (POWER_DOWN_PIN_IN |=> POWER_DOWN_OUT) else $error("power down pin ignored");
    a_iso_pin: assert property (ISOLATE_PIN_IN |=> !MII_OUTPUT_ENABLE_OUT) else $error("isolate pin ignored");
    a_sc_zero: assert property (!BASIC_CONTROL_REG_OUT[15] && !BASIC_CONTROL_REG_OUT[9])
        else $error("self-clearing bit reads one");
    a_loop_medium: assert property (LOOPBACK_ENABLE_OUT |-> !MEDIUM_TX_ENABLE_OUT && !MEDIUM_RX_ENABLE_OUT)
        else $error("medium active in loopback");
endmodule
bind pcr_control_reg pcr_control_reg_asserts pcr_control_reg_asserts_inst (.CLK_SYS_IN, .NRST_IN,
    .TECHNOLOGY_SELECT_PINS_IN, .AUTONEG_ABILITY_PIN_IN, .POWER_DOWN_PIN_IN, .ISOLATE_PIN_IN,
    .SPEED_100_OUT, .LOOPBACK_ENABLE_OUT, .MEDIUM_TX_ENABLE_OUT, .MEDIUM_RX_ENABLE_OUT,
    .POWER_DOWN_OUT, .MII_OUTPUT_ENABLE_OUT, .AUTONEG_ACTIVE_OUT, .AUTONEG_RESTART_OUT,
    .SOFT_RESET_OUT, .BASIC_CONTROL_REG_OUT);

//--- pcr_map.vh
// Register map, field positions, reset values and strap codes for the basic control register.
// Notes on behaviour
// - Reset bit resets all registers, self-clears.
// - Loopback blocks medium transmit and receive.
// - Speed bit: one 100, zero 10; reset one.
// - Speed writable only tech zero, autoneg off.
// - Tech 10-only, autoneg off: speed forced zero.
// - Tech 100-only, autoneg off: speed forced one.
// - Autoneg enabled: speed unwritable, no effect; the code still drives SPEED_100_OUT from the bit.
// - Tech returning to zero keeps speed value.
// - Autoneg enable settable only with ability pin.
// - Autoneg off: speed from bit or pins.
// - Ability pin rising: enable stays zero until written.
// - Power-down bit or pin; management still answers.
// - Isolate floats MII outputs, management still answers.
// - Isolate reset value follows float default strap.
// - Isolate pin also forces isolate mode.
// - Autonegotiation starts automatically at power-up.
// - Restart bit restarts autonegotiation, self-clears.
// - Access over MDIO/MDC; unsupported reads leave MDIO undriven.
`ifndef PCR_MAP_VH
`define PCR_MAP_VH
`define PCR_ADDR_CTRL      5'h00
`define PCR_BIT_RESET      15
`define PCR_BIT_LOOPBACK   14
`define PCR_BIT_SPEED      13
`define PCR_BIT_ANEG_EN    12
`define PCR_BIT_POWER_DOWN_REQUEST      11
`define PCR_BIT_ISOLATE    10
`define PCR_BIT_RESTART    9
`define PCR_BIT_DUPLEX     8
`define PCR_RST_LOOPBACK   1'h0
`define PCR_RST_SPEED      1'h1
`define PCR_RST_POWER_DOWN_REQUEST      1'h0
`define PCR_RST_DUPLEX     1'h0
`define PCR_TECH_ANY       3'h0
`define PCR_TECH_10_ONLY_A 3'h1
`define PCR_TECH_10_ONLY_B 3'h2
`define PCR_TECH_10_ONLY_C 3'h3
`define PCR_TECH_100_ONLY_A 3'h4
`define PCR_TECH_100_ONLY_B 3'h5
`define PCR_TECH_100_ONLY_C 3'h6
`define PCR_FRAME_BITS     6'h20
`endif

//--- pcr_mdio_slave.v
// Serial management frame engine: decodes MDC-sampled MDIO frames.
`timescale 1ns/1ps
`include "pcr_map.vh"
module pcr_mdio_slave (
    input  wire        clk_in,
    input  wire        nrst_in,
    input  wire        soft_rst_in,
    input  wire        mdc_in,
    input  wire        mdio_in,
    input  wire [4:0]  phy_addr_in,
    input  wire [15:0] rd_data_in,
    output reg         mdio_out,
    output reg         mdio_oe_out,
    output reg         wr_stb_out,
    output reg  [4:0]  reg_addr_out,
    output reg  [15:0] wr_data_out
);
    localparam ST_IDLE = 3'h0;
    localparam ST_HEAD = 3'h1;
    localparam ST_TA   = 3'h2;
    localparam ST_RD   = 3'h3;
    localparam ST_WR   = 3'h4;

    reg [2:0]  state_r;
    reg [5:0]  cnt_r;
    reg [13:0] head_r;
    reg [15:0] shift_r;
    reg        mdc_d_r;
    reg        own_r;
    wire       rise = mdc_in & ~mdc_d_r;
    wire       fall = ~mdc_in & mdc_d_r;
    wire       hit  = (head_r[9:5] == phy_addr_in) || (head_r[9:5] == 5'h00);

    // MDIO is sampled on MDC rising edges and driven after falling edges.
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r      <= ST_IDLE;
            cnt_r        <= 6'h00;
            head_r       <= 14'h0000;
            shift_r      <= 16'h0000;
            mdc_d_r      <= 1'b0;
            own_r        <= 1'b0;
            mdio_out     <= 1'b1;
            mdio_oe_out  <= 1'b0;
            wr_stb_out   <= 1'b0;
            reg_addr_out <= 5'h00;
            wr_data_out  <= 16'h0000;
        end else if (soft_rst_in) begin
            state_r     <= ST_IDLE;
            cnt_r       <= 6'h00;
            mdio_oe_out <= 1'b0;
            wr_stb_out  <= 1'b0;
            mdc_d_r     <= mdc_in;
        end else begin
            mdc_d_r    <= mdc_in;
            wr_stb_out <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (rise) begin
                        if (mdio_in) begin
                            cnt_r <= (cnt_r == `PCR_FRAME_BITS) ? cnt_r : cnt_r + 6'h01;
                        end else if (cnt_r == `PCR_FRAME_BITS) begin
                            state_r <= ST_HEAD;
                            cnt_r   <= 6'h00;
                            head_r  <= 14'h0000;
                        end else begin
                            cnt_r <= 6'h00;
                        end
                    end
                end
                ST_HEAD: begin
                    if (rise) begin
                        head_r <= {head_r[12:0], mdio_in};
                        cnt_r  <= cnt_r + 6'h01;
                        if (cnt_r == 6'h0C) begin
                            state_r <= ST_TA;
                            cnt_r   <= 6'h00;
                        end
                    end
                end
                ST_TA: begin
                    // Header bits: start(1), op(2), phy(5), reg(5).
                    reg_addr_out <= head_r[4:0];
                    own_r <= hit && (head_r[4:0] == `PCR_ADDR_CTRL);
                    if (head_r[11:10] == 2'h2) begin
                        state_r <= ST_RD;
                        shift_r <= rd_data_in;
                    end else if (head_r[11:10] == 2'h1) begin
                        state_r <= ST_WR;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_RD: begin
                    if (fall) begin
                        // First turnaround bit stays released so the station can let go of the line.
                        // Then a zero and sixteen data bits follow; silent when not ours.
                        mdio_oe_out <= own_r && (cnt_r != 6'h00) && (cnt_r <= 6'h11);
                        mdio_out    <= (cnt_r <= 6'h01) ? 1'b0 : shift_r[15];
                        if (cnt_r >= 6'h02) begin
                            shift_r <= {shift_r[14:0], 1'b0};
                        end
                        cnt_r <= cnt_r + 6'h01;
                        if (cnt_r == 6'h12) begin
                            state_r <= ST_IDLE;
                            cnt_r   <= 6'h00;
                        end
                    end
                end
                ST_WR: begin
                    if (rise) begin
                        cnt_r <= cnt_r + 6'h01;
                        if (cnt_r >= 6'h02) begin
                            shift_r <= {shift_r[14:0], mdio_in};
                        end
                        if (cnt_r == 6'h11) begin
                            wr_data_out <= {shift_r[14:0], mdio_in};
                            wr_stb_out  <= own_r && hit;
                            state_r     <= ST_IDLE;
                            cnt_r       <= 6'h00;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule

//--- pcr_sta_model.sv
// Station manager model that runs management frames on the serial pins.
`timescale 1ns/1ps
module pcr_sta_model (
    // Clock
    input  wire clk_in,
    // Serial pins
    input  wire mdio_in,
    input  wire dev_oe_in,
    output reg  mdc_out,
    output reg  mdio_out,
    output reg  mdio_oe_out
);
    reg oe_seen_r;
    initial begin
        mdc_out = 1'b0;
        mdio_out = 1'b1;
        mdio_oe_out = 1'b0;
        oe_seen_r = 1'b0;
    end
    // Four clocks per half period keeps the management clock well below the device clock.
    task bit_cyc(input logic b, output logic s);
        begin
            mdio_out <= b;
            repeat (4) @(posedge clk_in);
            mdc_out <= 1'b1;
            s = mdio_in;
            oe_seen_r = oe_seen_r | dev_oe_in;
            repeat (4) @(posedge clk_in);
            mdc_out <= 1'b0;
        end
    endtask
    task frame(input logic rd, input logic [4:0] phy, ra, input logic [15:0] wd, output logic [15:0] rdat);
        logic [31:0] hdr;
        logic        s;
        integer      i;
        begin
            hdr = {2'b01, rd ? 2'b10 : 2'b01, phy, ra, rd ? 2'b11 : 2'b10, wd};
            oe_seen_r = 1'b0;
            @(posedge clk_in);
            mdio_oe_out <= 1'b1;
            for (i = 0; i < 32; i = i + 1)
                bit_cyc(1'b1, s);
            for (i = 31; i >= 0; i = i - 1) begin
                if (rd && i == 17)
                    mdio_oe_out <= 1'b0;
                bit_cyc(hdr[i], s);
                rdat = {rdat[14:0], s};
            end
            mdio_oe_out <= 1'b0;
        end
    endtask
endmodule

//--- testbench.sv
// Self-checking bench for the basic control register block.
`timescale 1ns/1ps
module testbench;
    reg          clk, nrst, abil, flt, pdp, isop;
    reg  [2:0]   tech;
    wire         mdc, md, moe, dout, doe, mdio_w;
    wire         spd, lpb, txe, rxe, pdo, miie, anrs, sres, fdx, ane;
    wire [15:0]  regv;
    integer      n_mismatch, checks;
    integer      n_rs = 0;
    integer      n_sr = 0;
    logic [15:0] v;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // The line has a pull-up, so it rests high when nobody drives it.
    assign mdio_w = doe ? dout : (moe ? md : 1'b1);
    pcr_control_reg pcr_control_reg_inst (.CLK_SYS_IN(clk), .NRST_IN(nrst), .MDC_IN(mdc), .MDIO_IN(mdio_w),
        .MDIO_OUT(dout), .MDIO_OE_OUT(doe), .PHY_ADDR_IN(5'h01), .TECHNOLOGY_SELECT_PINS_IN(tech),
        .AUTONEG_ABILITY_PIN_IN(abil), .FLOAT_DEFAULT_STRAP_IN(flt), .POWER_DOWN_PIN_IN(pdp),
        .ISOLATE_PIN_IN(isop), .SPEED_100_OUT(spd), .FULL_DUPLEX_OUT(fdx), .LOOPBACK_ENABLE_OUT(lpb),
        .MEDIUM_TX_ENABLE_OUT(txe), .MEDIUM_RX_ENABLE_OUT(rxe), .POWER_DOWN_OUT(pdo),
        .MII_OUTPUT_ENABLE_OUT(miie), .AUTONEG_ACTIVE_OUT(ane), .AUTONEG_RESTART_OUT(anrs),
        .SOFT_RESET_OUT(sres), .BASIC_CONTROL_REG_OUT(regv));
    pcr_sta_model pcr_sta_model_inst (.clk_in(clk), .mdio_in(mdio_w), .dev_oe_in(doe), .mdc_out(mdc),
        .mdio_out(md), .mdio_oe_out(moe));
    always @(posedge clk) begin
        if (anrs === 1'b1)
            n_rs <= n_rs + 1;
        if (sres === 1'b1)
            n_sr <= n_sr + 1;
    end
    task chk(input logic [15:0] seen, exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input logic [15:0] d);
        begin
            pcr_sta_model_inst.frame(1'b0, 5'h01, 5'h00, d, v);
            repeat (3) @(posedge clk);
        end
    endtask
    task rc(input logic [15:0] e);
        begin
            pcr_sta_model_inst.frame(1'b1, 5'h01, 5'h00, 16'hFFFF, v);
            chk(v, e);
        end
    endtask
    task pins(input logic [2:0] t, input logic a, p, i);
        begin
            tech <= t;
            abil <= a;
            pdp <= p;
            isop <= i;
            repeat (4) @(posedge clk);
        end
    endtask
    task give_verdict;
        begin
            $display("Mismatches %0d, comparisons %0d", n_mismatch, checks);
            if (n_mismatch == 0 && checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        give_verdict;
    end
    initial begin
        n_mismatch = 0;
        checks = 0;
        nrst = 1'b0;
        tech = 3'h0;
        abil = 1'b1;
        flt = 1'b1;
        pdp = 1'b0;
        isop = 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        chk(miie, 16'h0);
        chk(n_rs[15:0], 16'h1);
        rc(16'h3400);
        chk(ane, 16'h1);
        wr(16'h1200);
        chk(n_rs[15:0], 16'h2);
        rc(16'h3000);
        wr(16'h0000);
        wr(16'h0000);
        rc(16'h0000);
        chk(spd, 16'h0);
        pins(3'h4, 1'b1, 1'b0, 1'b0);
        chk(spd, 16'h1);
        wr(16'h0000);
        rc(16'h2000);
        pins(3'h0, 1'b1, 1'b0, 1'b0);
        rc(16'h2000);
        pins(3'h1, 1'b1, 1'b0, 1'b0);
        chk(spd, 16'h0);
        wr(16'h2000);
        rc(16'h0000);
        pins(3'h0, 1'b1, 1'b0, 1'b0);
        wr(16'h4900);
        rc(16'h4900);
        chk({lpb, txe, rxe, pdo}, 16'h9);
        chk(fdx, 16'h1);
        pins(3'h0, 1'b1, 1'b0, 1'b1);
        chk(miie, 16'h0);
        rc(16'h4900);
        wr(16'h4000);
        pins(3'h0, 1'b1, 1'b1, 1'b0);
        chk(pdo, 16'h1);
        pins(3'h0, 1'b1, 1'b0, 1'b0);
        wr(16'h5400);
        chk(miie, 16'h0);
        rc(16'h5400);
        pins(3'h0, 1'b0, 1'b0, 1'b0);
        rc(16'h4400);
        pins(3'h0, 1'b1, 1'b0, 1'b0);
        rc(16'h4400);
        pcr_sta_model_inst.frame(1'b1, 5'h01, 5'h01, 16'hFFFF, v);
        chk(pcr_sta_model_inst.oe_seen_r, 16'h0);
        pcr_sta_model_inst.frame(1'b1, 5'h02, 5'h00, 16'hFFFF, v);
        chk(pcr_sta_model_inst.oe_seen_r, 16'h0);
        pcr_sta_model_inst.frame(1'b1, 5'h00, 5'h00, 16'hFFFF, v);
        chk(v, 16'h4400);
        wr(16'h5400);
        wr(16'h8000);
        chk(n_sr[15:0], 16'h1);
        chk(lpb, 16'h0);
        rc(16'h3400);
        give_verdict;
    end
endmodule
